// File: nonblocking_stream_fifo.v
// Stream channel FIFO with try-push/try-pop and blocking access.
// Assumes one producer and one consumer on core_clk, srst shared.
`timescale 1ns/1ps
`include "stream_fifo_defines.vh"

module nonblocking_stream_fifo #(
  parameter DEPTH = `SF_DEPTH,
  parameter PTR_W = `SF_PTR_WIDTH,
  parameter CNT_W = `SF_CNT_WIDTH
) (
  // Clock and reset
  input  wire                        core_clk,
  input  wire                        srst,
  // Channel configuration
  input  wire [1:0]                  port_protocol,
  // Producer side
  input  wire                        try_push,
  input  wire                        push_req,
  input  wire [`SF_DATA_WIDTH-1:0]   push_data,
  output wire                        push_ok,
  output wire                        push_wait,
  // Consumer side, request
  input  wire                        try_pop,
  input  wire                        pop_req,
  output wire                        pop_ok,
  output wire                        pop_wait,
  // Consumer side, delivered data
  output wire                        rd_valid,
  input  wire                        rd_ready,
  output wire [`SF_DATA_WIDTH-1:0]   rd_data,
  // Status
  output wire                        full,
  output wire                        empty,
  output wire [CNT_W-1:0]            level
);

  // ----------------------------------------------------------------
  // Usage notes
  // ----------------------------------------------------------------
  // Try accesses answer in their own cycle, never stall
  // Refused access leaves storage, pointers and count alone
  // Blocking requests held high until their ok pulses
  // Pop also waits while the output buffer holds two words
  // Raising DEPTH needs PTR_W and CNT_W raised to match

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  reg  [`SF_DATA_WIDTH-1:0] mem [0:DEPTH-1];
  reg  [PTR_W-1:0]          wr_ptr;
  reg  [PTR_W-1:0]          rd_ptr;
  reg  [CNT_W-1:0]          count;

  wire                      nb_allowed;
  wire                      push_any;
  wire                      pop_any;
  wire                      do_push;
  wire                      do_pop;
  wire                      buf_ready;
  wire [`SF_DATA_WIDTH-1:0] head_word;
  reg  [PTR_W-1:0]          next_wr_ptr;
  reg  [PTR_W-1:0]          next_rd_ptr;
  reg  [CNT_W-1:0]          next_count;

  // Pointer advance with wrap at depth
  function [PTR_W-1:0] ptr_next;
    input [PTR_W-1:0] p;
    begin
      if (p == DEPTH - 1)
        ptr_next = {PTR_W{1'b0}};
      else
        ptr_next = p + {{(PTR_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Request present: blocking always, try only when offered
  function req_seen;
    input blocking;
    input attempt;
    input offered;
    begin
      req_seen = blocking || (attempt && offered);
    end
  endfunction

  // Occupancy one step up, full gates it
  function [CNT_W-1:0] cnt_up;
    input [CNT_W-1:0] c;
    begin
      cnt_up = c + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Occupancy one step down, empty gates it
  function [CNT_W-1:0] cnt_down;
    input [CNT_W-1:0] c;
    begin
      cnt_down = c - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // full at depth
  assign full  = (count == DEPTH[CNT_W-1:0]);
  assign empty = (count == `SF_CNT_RESET);
  assign level = count;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  // protocol gate
  assign nb_allowed = (port_protocol == `SF_PROTO_PLAIN);
  assign push_any   = req_seen(push_req, try_push, nb_allowed);
  assign pop_any    = req_seen(pop_req, try_pop, nb_allowed);

  assign do_push = push_any && !full;
  assign do_pop  = pop_any && !empty && buf_ready;

  assign push_ok = do_push;
  assign pop_ok  = do_pop;

  assign push_wait = push_req && !do_push;
  assign pop_wait  = pop_req && !do_pop;

  assign head_word = mem[rd_ptr];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // ordered pointers
  // Write pointer moves only on an accepted push
  always @* begin
    next_wr_ptr = wr_ptr;
    if (do_push)
      next_wr_ptr = ptr_next(wr_ptr);
  end

  // Read pointer moves only on an accepted pop
  always @* begin
    next_rd_ptr = rd_ptr;
    if (do_pop)
      next_rd_ptr = ptr_next(rd_ptr);
  end

  // Occupancy follows accepted accesses; a pair cancels out
  always @* begin
    case ({do_push, do_pop})
      2'b10:   next_count = cnt_up(count);
      2'b01:   next_count = cnt_down(count);
      default: next_count = count;
    endcase
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  // Pointers, cleared together so storage reads empty
  always @(posedge core_clk) begin
    if (srst) begin
      wr_ptr <= {PTR_W{`SF_PTR_RESET}};
      rd_ptr <= {PTR_W{`SF_PTR_RESET}};
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Occupancy behind full, empty and level
  always @(posedge core_clk) begin
    if (srst) begin
      count <= `SF_CNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // Storage write
  // ----------------------------------------------------------------
  // Word storage, no reset: count guards every read
  always @(posedge core_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  // ----------------------------------------------------------------
  // Output buffer toward consumer
  // ----------------------------------------------------------------
  stream_skid_buffer u_out_buf (
    .core_clk  (core_clk),
    .srst      (srst),
    .in_valid  (do_pop),
    .in_ready  (buf_ready),
    .in_data   (head_word),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

endmodule // nonblocking_stream_fifo

// File: stream_fifo_defines.vh
// Constants for the nonblocking stream FIFO channel.
// Assumes inclusion by bare name from the design files.
`ifndef STREAM_FIFO_DEFINES_VH
`define STREAM_FIFO_DEFINES_VH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define SF_DATA_WIDTH   32
`define SF_DEPTH        2
`define SF_PTR_WIDTH    1
`define SF_CNT_WIDTH    2
`define SF_SKID_ENTRIES 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SF_PTR_RESET    1'b0
`define SF_CNT_RESET    2'h0

// ----------------------------------------------------------------
// Port protocol modes
// ----------------------------------------------------------------
`define SF_PROTO_PLAIN  2'h0
`define SF_PROTO_HS     2'h1
`define SF_PROTO_AXIS   2'h2

`endif

// File: stream_skid_buffer.v
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "stream_fifo_defines.vh"

module stream_skid_buffer (
  // Clock and reset
  input  wire                        core_clk,
  input  wire                        srst,
  // Filling side
  input  wire                        in_valid,
  output wire                        in_ready,
  input  wire [`SF_DATA_WIDTH-1:0]   in_data,
  // Draining side
  output wire                        out_valid,
  input  wire                        out_ready,
  output wire [`SF_DATA_WIDTH-1:0]   out_data
);

  reg  [`SF_DATA_WIDTH-1:0] slot0;
  reg  [`SF_DATA_WIDTH-1:0] slot1;
  reg  [1:0]                fill;

  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  assign in_ready  = (fill != `SF_SKID_ENTRIES);
  assign out_valid = (fill != `SF_CNT_RESET);
  assign out_data  = slot0;

  // Shift register storage, head in slot0
  always @(posedge core_clk) begin
    if (srst) begin
      fill <= `SF_CNT_RESET;
    end else begin
      case ({in_valid && in_ready, out_valid && out_ready})
        2'b10: fill <= fill + 2'h1;
        2'b01: fill <= fill - 2'h1;
        default: fill <= fill;
      endcase
    end
  end

  // Data movement, no reset needed on payload
  always @(posedge core_clk) begin
    if (out_valid && out_ready) begin
      slot0 <= (fill == `SF_SKID_ENTRIES) ? slot1 : in_data;
      if (in_valid && in_ready && fill == `SF_SKID_ENTRIES)
        slot1 <= in_data;
    end else if (in_valid && in_ready) begin
      if (fill == 2'h0)
        slot0 <= in_data;
      else
        slot1 <= in_data;
    end
  end

endmodule // stream_skid_buffer

// File: stream_fifo_monitor.sv
// Port assertions for the stream FIFO channel.
// Assumes one clock, bound into every channel instance.
`timescale 1ns/1ps
module stream_fifo_monitor #(
  parameter DEPTH = 2,
  parameter CNT_W = 2
) (
  // Clock, reset, configuration
  input wire logic             core_clk,
  input wire logic             srst,
  input wire logic [1:0]       port_protocol,
  // Requests and answers
  input wire logic             try_push,
  input wire logic             push_req,
  input wire logic             push_ok,
  input wire logic             push_wait,
  input wire logic             pop_ok,
  // Delivery and status
  input wire logic             rd_valid,
  input wire logic             rd_ready,
  input wire logic             full,
  input wire logic             empty,
  input wire logic [31:0]      rd_data,
  input wire logic [CNT_W-1:0] level
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  full_at_depth_a: assert property (full == (level == DEPTH))
    else $error("full flag wrong");
  empty_at_zero_a: assert property (empty == (level == 0))
    else $error("empty flag wrong");
  push_refused_a: assert property (full |-> !push_ok)
    else $error("push taken while full");
  push_taken_a: assert property (try_push && !port_protocol && !full
    |-> push_ok)
    else $error("try push not taken");
  proto_guard_a: assert property (port_protocol && !push_req
    |-> !push_ok)
    else $error("try push taken off plain protocol");
  pop_refused_a: assert property (empty |-> !pop_ok)
    else $error("pop taken while empty");
  level_step_a: assert property (push_ok && !pop_ok
    |=> level == $past(level) + 1'b1)
    else $error("level did not step");
  push_wait_a: assert property (push_wait == (push_req && !push_ok))
    else $error("wait flag wrong");
  word_hold_a: assert property (rd_valid && !rd_ready
    |=> rd_valid && $stable(rd_data))
    else $error("word dropped in stall");

  cover property (push_ok && pop_ok);
  cover property (full && try_push);
  cover property (push_wait);
endmodule // stream_fifo_monitor

bind nonblocking_stream_fifo stream_fifo_monitor #(
  .DEPTH (DEPTH),
  .CNT_W (CNT_W)
) stream_fifo_monitor_inst (
  .core_clk      (core_clk),
  .srst          (srst),
  .port_protocol (port_protocol),
  .try_push      (try_push),
  .push_req      (push_req),
  .push_ok       (push_ok),
  .push_wait     (push_wait),
  .pop_ok        (pop_ok),
  .rd_valid      (rd_valid),
  .rd_ready      (rd_ready),
  .full          (full),
  .empty         (empty),
  .rd_data       (rd_data),
  .level         (level)
);

// File: stream_sink_model.sv
// Consumer process draining the channel output.
// Assumes the bench asks for stalls through hold_off.
`timescale 1ns/1ps
module stream_sink_model (
  input  wire core_clk,
  input  wire srst,
  input  wire hold_off,
  output reg  rd_ready = 1'b0
);
  always @(posedge core_clk) begin
    rd_ready <= !srst && !hold_off;
  end
endmodule // stream_sink_model

// File: tb_top.sv
// Self-checking bench for the stream FIFO channel.
// Assumes the sink model drives rd_ready.
`timescale 1ns/1ps
module tb_top;
  reg core_clk = 1'b0, srst = 1'b1, try_push = 1'b0, push_req = 1'b0;
  reg try_pop = 1'b0, pop_req = 1'b0, hold_off = 1'b1;
  reg [1:0] port_protocol = 2'h0;
  reg [31:0] push_data = 32'h0;
  wire push_ok, push_wait, pop_ok, pop_wait, rd_valid, rd_ready, full, empty;
  wire [31:0] rd_data;
  wire [1:0] level;
  integer fails = 0, num_checks = 0, cyc = 0;
  logic [31:0] exp_q[$];

  always #20 core_clk = ~core_clk;
  nonblocking_stream_fifo nonblocking_stream_fifo_inst (
    .core_clk(core_clk), .srst(srst), .port_protocol(port_protocol),
    .try_push(try_push), .push_req(push_req), .push_data(push_data),
    .push_ok(push_ok), .push_wait(push_wait), .try_pop(try_pop),
    .pop_req(pop_req), .pop_ok(pop_ok), .pop_wait(pop_wait),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .full(full), .empty(empty), .level(level));
  stream_sink_model stream_sink_model_inst (.core_clk(core_clk),
    .srst(srst), .hold_off(hold_off), .rd_ready(rd_ready));

  task chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task conclude;
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One access cycle: pk/pp bit 0 try access, bit 1 blocking request
  task acc(input [1:0] pk, input [1:0] pp, input [31:0] d, input ep, eq);
    @(posedge core_clk);
    try_push <= pk[0];
    push_req <= pk[1];
    try_pop <= pp[0];
    pop_req <= pp[1];
    push_data <= d;
    @(negedge core_clk);
    chk(push_ok === ep && pop_ok === eq && push_wait === (pk[1] && !ep)
      && pop_wait === (pp[1] && !eq), "answer");
    if (ep) exp_q.push_back(d);
  endtask

  // Delivered words against acceptance order, and hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
      chk(exp_q.size() > 0 && rd_data === exp_q.pop_front(), "order");
    if (cyc == 3000) begin
      fails++;
      conclude;
    end
  end

  initial begin
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    chk(empty === 1'b1 && full === 1'b0 && level === 2'h0, "idle");
    acc(2'h1, 0, 32'h1111_0000, 1, 0);
    acc(2'h1, 0, 32'h2222_0001, 1, 0);
    acc(2'h1, 0, 32'h3333_0002, 0, 0);
    chk(full === 1'b1 && level === 2'h2, "full");
    acc(2'h1, 1, 32'h4444_0003, 0, 1);
    acc(2'h1, 1, 32'h5555_0004, 1, 1);
    acc(2'h0, 1, 32'h0, 0, 0);
    @(posedge core_clk);
    hold_off <= 1'b0;
    repeat (4) acc(2'h0, 0, 32'h0, 0, 0);
    acc(2'h0, 1, 32'h0, 0, 1);
    acc(2'h0, 1, 32'h0, 0, 0);
    chk(empty === 1'b1, "empty");
    acc(2'h0, 2'h2, 32'h0, 0, 0);
    acc(2'h1, 2'h2, 32'hbbbb_0008, 1, 0);
    acc(2'h0, 2'h2, 32'h0, 0, 1);
    @(posedge core_clk);
    port_protocol <= 2'h1;
    acc(2'h1, 1, 32'h6666_0000, 0, 0);
    acc(2'h2, 0, 32'h7777_0005, 1, 0);
    acc(2'h2, 0, 32'h8888_0006, 1, 0);
    acc(2'h2, 0, 32'h9999_0007, 0, 0);
    @(posedge core_clk);
    port_protocol <= 2'h0;
    acc(2'h2, 1, 32'h9999_0007, 0, 1);
    acc(2'h2, 1, 32'h9999_0007, 1, 1);
    acc(2'h0, 1, 32'h0, 0, 1);
    repeat (4) acc(2'h0, 0, 32'h0, 0, 0);
    chk(exp_q.size() == 0, "lost");
    conclude;
  end
endmodule // tb_top
